// ==== common/cvsc_defs.svh ====
// Purpose: offsets, field positions and reset values of the cursor,
//          split-screen and colour register slice
// Assumes: word-wide plain register port, byte addresses as printed
// Notes:   control bits without a printed home live in cvsc_ctrl
`ifndef CVSC_DEFS_SVH
`define CVSC_DEFS_SVH

// =========================================================
// register offsets (byte addresses, low 16 bits)
`define CVSC_OFF_CURSOR_Y   16'h8358
`define CVSC_OFF_SS_CMP     16'h835c
`define CVSC_OFF_CUR_COLOR  16'h8360
`define CVSC_OFF_RSVD_A     16'h8364
`define CVSC_OFF_BORDER     16'h8368
`define CVSC_OFF_RSVD_B     16'h836c
`define CVSC_OFF_CTRL       16'h8380
`define CVSC_OFF_STATUS     16'h8384

// =========================================================
// field positions
`define CVSC_SKIP_HI        15
`define CVSC_SKIP_LO        11
`define CVSC_CURY_HI        9
`define CVSC_CURY_LO        0
`define CVSC_SSCMP_HI       10
`define CVSC_SSCMP_LO       0
`define CVSC_CLR1_HI        15
`define CVSC_CLR1_LO        8
`define CVSC_CLR0_HI        7
`define CVSC_CLR0_LO        0
`define CVSC_CTRL_SS_EN     0
`define CVSC_CTRL_CUR_EN    1
`define CVSC_CTRL_YCMP_EN   2
`define CVSC_CTRL_BPP8      3
`define CVSC_BDR_HI         7
`define CVSC_BDR_LO         0
`define CVSC_CTRL_HI        3
`define CVSC_CTRL_LO        0

// =========================================================
// reset values and sizes
`define CVSC_ZERO32         32'h0000_0000
`define CVSC_ZERO11         11'h000
`define CVSC_ZERO8          8'h00
`define CVSC_ZERO5          5'h00
`define CVSC_ZERO10         10'h000
`define CVSC_ZERO4          4'h0
`define CVSC_ONE11          11'h001
`define CVSC_PAT_LINES      6'h20

`endif

// ==== common/cvsc_pkg.sv ====
// Purpose: shared types of the cursor, split-screen and colour slice
// Assumes: nothing
// Notes:   pixel class selects the palette index source
package cvsc_pkg;
  typedef enum logic [1:0] {
    CVSC_PIX_ACTIVE = 2'b00,
    CVSC_PIX_CUR0   = 2'b01,
    CVSC_PIX_CUR1   = 2'b10,
    CVSC_PIX_BORDER = 2'b11
  } cvsc_pix_e;
  typedef logic [10:0] cvsc_line_t;
endpackage

// ==== rtl/cvsc_sync.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock, active-low asynchronous reset
// Notes:   the first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module cvsc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_nxt;

  // =========================================================
  // next values
  always_comb begin
    s1_nxt = ce ? d : s1_r;
    q_nxt  = ce ? s1_r : q;
  end

  // two stages
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= s1_nxt;
      q    <= q_nxt;
    end
  end
endmodule // cvsc_sync
`default_nettype wire

// ==== rtl/cvsc_regs.sv ====
// Purpose: cursor vertical position, split-screen compare and colour
//          index registers with the scan-line logic that uses them
// Assumes: core_clk is the dot clock; pixel class pins come from the
//          pixel path outside and are synchronised here
// Notes:   read data stand one cycle after the read strobe
//
// How it works
// - row skip sets first shown pattern line
// - cursor row field gives cursor top line
// - cursor row field may act as compare
// - split compare field marks lower region start
// - split hit resets fetch address to zero
// - colour indices used only in 8-bit mode
// - cursor colour one index from bits 15:8
// - cursor colour zero index from bits 7:0
// - border index drives overscan pixels
// - scan-line counter holds current line, dot clock
`timescale 1ns/1ns
`default_nettype none
`include "cvsc_defs.svh"
module cvsc_regs #(
  parameter int LINE_W = 11,
  parameter int PAT_W  = 5
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  input  wire logic        line_start,
  input  wire logic        frame_start,
  input  wire logic [1:0]  pix_class,
  output var  logic [LINE_W-1:0] scanline_counter,
  output var  logic        fetch_addr_reset,
  output var  logic        line_compare_hit,
  output var  logic        cursor_line_active,
  output var  logic [PAT_W-1:0] cursor_pattern_row,
  output var  logic [7:0]  palette_index,
  output var  logic        palette_index_valid
);
  // =========================================================
  // synchronised pixel-path pins
  logic [3:0] pins_s;
  logic       ls_s;
  logic       fs_s;
  logic [1:0] pc_s;

  cvsc_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .d        ({line_start, frame_start, pix_class}),
    .q        (pins_s)
  );
  assign ls_s = pins_s[3];
  assign fs_s = pins_s[2];
  assign pc_s = pins_s[1:0];

  // =========================================================
  // register file state
  logic [PAT_W-1:0]  row_skip_r,  row_skip_nxt;
  logic [9:0]        cur_row_r,   cur_row_nxt;
  logic [LINE_W-1:0] ss_cmp_r,    ss_cmp_nxt;
  logic [7:0]        clr1_r,      clr1_nxt;
  logic [7:0]        clr0_r,      clr0_nxt;
  logic [7:0]        border_r,    border_nxt;
  logic [3:0]        ctrl_r,      ctrl_nxt;
  logic [31:0]       rdata_nxt;
  logic              split_en;
  logic              cur_en;
  logic              ycmp_en;
  logic              bpp8;

  assign split_en = ctrl_r[`CVSC_CTRL_SS_EN];
  assign cur_en   = ctrl_r[`CVSC_CTRL_CUR_EN];
  assign ycmp_en  = ctrl_r[`CVSC_CTRL_YCMP_EN];
  assign bpp8     = ctrl_r[`CVSC_CTRL_BPP8];

  // register writes and read mux
  always_comb begin
    row_skip_nxt = row_skip_r;
    cur_row_nxt  = cur_row_r;
    ss_cmp_nxt   = ss_cmp_r;
    clr1_nxt     = clr1_r;
    clr0_nxt     = clr0_r;
    border_nxt   = border_r;
    ctrl_nxt     = ctrl_r;
    rdata_nxt    = `CVSC_ZERO32;
    if (wr) begin
      unique case (addr)
        `CVSC_OFF_CURSOR_Y: begin
          row_skip_nxt = wdata[`CVSC_SKIP_HI:`CVSC_SKIP_LO];
          cur_row_nxt  = wdata[`CVSC_CURY_HI:`CVSC_CURY_LO];
        end
        `CVSC_OFF_SS_CMP:    ss_cmp_nxt =
          wdata[`CVSC_SSCMP_HI:`CVSC_SSCMP_LO];
        `CVSC_OFF_CUR_COLOR: begin
          clr1_nxt = wdata[`CVSC_CLR1_HI:`CVSC_CLR1_LO];
          clr0_nxt = wdata[`CVSC_CLR0_HI:`CVSC_CLR0_LO];
        end
        `CVSC_OFF_BORDER:    border_nxt =
          wdata[`CVSC_BDR_HI:`CVSC_BDR_LO];
        `CVSC_OFF_CTRL:      ctrl_nxt   =
          wdata[`CVSC_CTRL_HI:`CVSC_CTRL_LO];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        `CVSC_OFF_CURSOR_Y:  rdata_nxt =
          {16'h0000, row_skip_r, 1'b0, cur_row_r};
        `CVSC_OFF_SS_CMP:    rdata_nxt = {21'h00_0000, ss_cmp_r};
        `CVSC_OFF_CUR_COLOR: rdata_nxt = {16'h0000, clr1_r, clr0_r};
        `CVSC_OFF_BORDER:    rdata_nxt = {24'h00_0000, border_r};
        `CVSC_OFF_CTRL:      rdata_nxt = {28'h000_0000, ctrl_r};
        `CVSC_OFF_STATUS:    rdata_nxt = {21'h00_0000, scanline_counter};
        default:             rdata_nxt = `CVSC_ZERO32;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      row_skip_r <= `CVSC_ZERO5;
      cur_row_r  <= `CVSC_ZERO10;
      ss_cmp_r   <= `CVSC_ZERO11;
      clr1_r     <= `CVSC_ZERO8;
      clr0_r     <= `CVSC_ZERO8;
      border_r   <= `CVSC_ZERO8;
      ctrl_r     <= `CVSC_ZERO4;
      rdata      <= `CVSC_ZERO32;
    end else if (ce) begin
      row_skip_r <= row_skip_nxt;
      cur_row_r  <= cur_row_nxt;
      ss_cmp_r   <= ss_cmp_nxt;
      clr1_r     <= clr1_nxt;
      clr0_r     <= clr0_nxt;
      border_r   <= border_nxt;
      ctrl_r     <= ctrl_nxt;
      rdata      <= rdata_nxt;
    end
  end

  // =========================================================
  // scan-line counter and compare logic
  logic [LINE_W-1:0] line_nxt;
  logic [LINE_W-1:0] cur_top;
  logic [5:0]        cur_span;
  logic [LINE_W-1:0] cur_delta;
  logic              in_cursor;
  logic              ss_hit;
  logic              y_hit;
  logic              fetch_nxt;
  logic              lch_nxt;
  logic              cla_nxt;
  logic [PAT_W-1:0]  row_nxt;

  assign cur_top   = {1'b0, cur_row_r};
  assign cur_span  = `CVSC_PAT_LINES - {1'b0, row_skip_r};
  assign cur_delta = scanline_counter - cur_top;
  assign in_cursor = (scanline_counter >= cur_top) &&
                     (cur_delta < {5'h00, cur_span});
  assign ss_hit    = split_en && (scanline_counter == ss_cmp_r);
  assign y_hit     = ycmp_en && (scanline_counter == cur_top);

  // next line, fetch reset and cursor row
  always_comb begin
    line_nxt = scanline_counter;
    if (fs_s) begin
      line_nxt = `CVSC_ZERO11;
    end else if (ls_s) begin
      line_nxt = scanline_counter + `CVSC_ONE11;
    end
    fetch_nxt = ls_s && ss_hit;
    lch_nxt   = ls_s && y_hit;
    cla_nxt   = cur_en && !ycmp_en && in_cursor;
    row_nxt   = row_skip_r + cur_delta[PAT_W-1:0];
  end

  // scan-line flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scanline_counter   <= `CVSC_ZERO11;
      fetch_addr_reset   <= 1'b0;
      line_compare_hit   <= 1'b0;
      cursor_line_active <= 1'b0;
      cursor_pattern_row <= `CVSC_ZERO5;
    end else if (ce) begin
      scanline_counter   <= line_nxt;
      fetch_addr_reset   <= fetch_nxt;
      line_compare_hit   <= lch_nxt;
      cursor_line_active <= cla_nxt;
      cursor_pattern_row <= row_nxt;
    end
  end

  // =========================================================
  // palette index path
  logic [7:0] pidx_nxt;
  logic       pval_nxt;

  // pick the index for the current pixel class
  always_comb begin
    pidx_nxt = `CVSC_ZERO8;
    pval_nxt = 1'b0;
    if (bpp8) begin
      unique case (cvsc_pkg::cvsc_pix_e'(pc_s))
        cvsc_pkg::CVSC_PIX_CUR1: begin
          pidx_nxt = clr1_r;
          pval_nxt = 1'b1;
        end
        cvsc_pkg::CVSC_PIX_CUR0: begin
          pidx_nxt = clr0_r;
          pval_nxt = 1'b1;
        end
        cvsc_pkg::CVSC_PIX_BORDER: begin
          pidx_nxt = border_r;
          pval_nxt = 1'b1;
        end
        cvsc_pkg::CVSC_PIX_ACTIVE: ;
      endcase
    end
  end

  // palette output flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      palette_index       <= `CVSC_ZERO8;
      palette_index_valid <= 1'b0;
    end else if (ce) begin
      palette_index       <= pidx_nxt;
      palette_index_valid <= pval_nxt;
    end
  end

  // =========================================================
  // checks
  property p_split_reset;
    @(posedge core_clk) disable iff (!nrst)
      (ce && ls_s && split_en && scanline_counter == ss_cmp_r)
      |=> fetch_addr_reset;
  endproperty
  a_split_reset: assert property (p_split_reset)
    else $error("split hit did not reset fetch address");

  property p_no_split;
    @(posedge core_clk) disable iff (!nrst)
      (ce && !split_en && !wr) |=> !fetch_addr_reset;
  endproperty
  a_no_split: assert property (p_no_split)
    else $error("fetch reset without split enable");

  property p_clr1;
    @(posedge core_clk) disable iff (!nrst)
      (ce && bpp8 && pc_s == cvsc_pkg::CVSC_PIX_CUR1 && !wr) |=>
      (palette_index == $past(clr1_r) && palette_index_valid);
  endproperty
  a_clr1: assert property (p_clr1)
    else $error("cursor colour one index wrong");

  property p_clr0;
    @(posedge core_clk) disable iff (!nrst)
      (ce && bpp8 && pc_s == cvsc_pkg::CVSC_PIX_CUR0) |=>
      (palette_index == $past(clr0_r));
  endproperty
  a_clr0: assert property (p_clr0)
    else $error("cursor colour zero index wrong");

  property p_border;
    @(posedge core_clk) disable iff (!nrst)
      (ce && bpp8 && pc_s == cvsc_pkg::CVSC_PIX_BORDER) |=>
      (palette_index == $past(border_r));
  endproperty
  a_border: assert property (p_border)
    else $error("border index wrong");

  property p_bpp8;
    @(posedge core_clk) disable iff (!nrst)
      (ce && !bpp8) |=> !palette_index_valid;
  endproperty
  a_bpp8: assert property (p_bpp8)
    else $error("index valid outside 8-bit mode");

  sequence s_line_step;
    ce && ls_s && !fs_s;
  endsequence
  property p_count;
    @(posedge core_clk) disable iff (!nrst)
      s_line_step |=>
      (scanline_counter == $past(scanline_counter) + `CVSC_ONE11);
  endproperty
  a_count: assert property (p_count)
    else $error("scan-line counter did not advance");

  property p_cursor_top;
    @(posedge core_clk) disable iff (!nrst)
      (ce && cur_en && !ycmp_en && scanline_counter == cur_top) |=>
      (cursor_line_active && cursor_pattern_row == $past(row_skip_r));
  endproperty
  a_cursor_top: assert property (p_cursor_top)
    else $error("cursor top line or first row wrong");

  property p_ycmp;
    @(posedge core_clk) disable iff (!nrst)
      (ce && ycmp_en) |=> !cursor_line_active;
  endproperty
  a_ycmp: assert property (p_ycmp)
    else $error("cursor shown while row field is a compare");
endmodule // cvsc_regs
`default_nettype wire

// ==== verification/cvsc_pix_src.sv ====
// Purpose: pixel path model feeding the scan-line and pixel class pins
// Assumes: pins change right after a rising edge, one-cycle pulses
// Notes:   gap sets how many idle cycles follow each line pulse; a frame pulse is followed by 4
`timescale 1ns/1ns
`default_nettype none
module cvsc_pix_src (
  input  wire logic       core_clk,
  output var  logic       line_start,
  output var  logic       frame_start,
  output var  logic [1:0] pix_class
);
  // pins idle low from time zero
  initial begin
    line_start  = 1'b0;
    frame_start = 1'b0;
    pix_class   = 2'b00;
  end

  // ==========================================================
  // one new scan line, then idle cycles
  task automatic next_line(input int gap);
    @(posedge core_clk);
    line_start <= 1'b1;
    @(posedge core_clk);
    line_start <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask

  // new frame zeroes the line count
  task automatic next_frame();
    @(posedge core_clk);
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // hold a pixel class until the index has settled
  task automatic show(input logic [1:0] cls);
    @(posedge core_clk);
    pix_class <= cls;
    repeat (5) @(posedge core_clk);
  endtask
endmodule // cvsc_pix_src
`default_nettype wire

// ==== verification/cvsc_regs_bench.sv ====
// Purpose: self-checking bench for the cursor, split and colour slice
// Assumes: pixel source model drives the pin side
// Notes:   expected values come from the register map and latencies
`timescale 1ns/1ns
`default_nettype none
`include "cvsc_defs.svh"
`define CHK(g, e) begin checks_done++; \
  if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cvsc_regs_bench;
  logic        core_clk;
  logic        nrst;
  logic        ce;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        line_start;
  logic        frame_start;
  logic [1:0]  pix_class;
  logic [10:0] scanline_counter;
  logic        fetch_addr_reset;
  logic        line_compare_hit;
  logic        cursor_line_active;
  logic [4:0]  cursor_pattern_row;
  logic [7:0]  palette_index;
  logic        palette_index_valid;
  int          err_total;
  int          checks_done;
  int          n_fetch;
  int          n_hit;
  int          cycles;
  int          base;

  cvsc_regs cvsc_regs_i (.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .line_start(line_start), .frame_start(frame_start),
    .pix_class(pix_class), .scanline_counter(scanline_counter),
    .fetch_addr_reset(fetch_addr_reset),
    .line_compare_hit(line_compare_hit),
    .cursor_line_active(cursor_line_active),
    .cursor_pattern_row(cursor_pattern_row),
    .palette_index(palette_index),
    .palette_index_valid(palette_index_valid));
  cvsc_pix_src cvsc_pix_src_i (.core_clk(core_clk),
    .line_start(line_start), .frame_start(frame_start),
    .pix_class(pix_class));

  // 100 ns dot clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // pulse counters and hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (fetch_addr_reset === 1'b1) n_fetch++;
    if (line_compare_hit === 1'b1) n_hit++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================================
  // register port tasks
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  task automatic lines(input int n);
    repeat (n) cvsc_pix_src_i.next_line(4);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks %0d", name, checks_done);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    addr = 16'h0000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    // reset values and field masks
    rd_chk(`CVSC_OFF_CUR_COLOR, 32'h0000_0000);
    wr32(`CVSC_OFF_CURSOR_Y, 32'hffff_ffff);
    rd_chk(`CVSC_OFF_CURSOR_Y, 32'h0000_fbff);
    wr32(`CVSC_OFF_SS_CMP, 32'hffff_ffff);
    rd_chk(`CVSC_OFF_SS_CMP, 32'h0000_07ff);
    wr32(`CVSC_OFF_RSVD_A, 32'hffff_ffff);
    rd_chk(`CVSC_OFF_RSVD_A, 32'h0000_0000);
    rd_chk(`CVSC_OFF_RSVD_B, 32'h0000_0000);
    end_test("registers");
    // palette indices, static entries chosen by software
    wr32(`CVSC_OFF_CUR_COLOR, 32'h0000_a55a);
    wr32(`CVSC_OFF_BORDER, 32'h0000_00c3);
    rd_chk(`CVSC_OFF_BORDER, 32'h0000_00c3);
    wr32(`CVSC_OFF_CTRL, 32'h0000_0000);
    cvsc_pix_src_i.show(cvsc_pkg::CVSC_PIX_CUR1);
    `CHK(palette_index_valid, 1'b0)
    wr32(`CVSC_OFF_CTRL, 32'h0000_0008);
    cvsc_pix_src_i.show(cvsc_pkg::CVSC_PIX_CUR1);
    `CHK({palette_index_valid, palette_index}, 9'h1_a5)
    cvsc_pix_src_i.show(cvsc_pkg::CVSC_PIX_CUR0);
    `CHK({palette_index_valid, palette_index}, 9'h1_5a)
    cvsc_pix_src_i.show(cvsc_pkg::CVSC_PIX_BORDER);
    `CHK({palette_index_valid, palette_index}, 9'h1_c3)
    cvsc_pix_src_i.show(cvsc_pkg::CVSC_PIX_ACTIVE);
    `CHK(palette_index_valid, 1'b0)
    // clock enable low drops a write
    ce <= 1'b0;
    wr32(`CVSC_OFF_CUR_COLOR, 32'h0000_ffff);
    ce <= 1'b1;
    rd_chk(`CVSC_OFF_CUR_COLOR, 32'h0000_a55a);
    end_test("palette");
    // split compare on and off
    wr32(`CVSC_OFF_SS_CMP, 32'h0000_0003);
    wr32(`CVSC_OFF_CTRL, 32'h0000_0001);
    cvsc_pix_src_i.next_frame();
    `CHK(scanline_counter, 11'h000)
    base = n_fetch;
    lines(6);
    `CHK(n_fetch - base, 1)
    `CHK(scanline_counter, 11'h006)
    rd_chk(`CVSC_OFF_STATUS, 32'h0000_0006);
    wr32(`CVSC_OFF_CTRL, 32'h0000_0000);
    cvsc_pix_src_i.next_frame();
    base = n_fetch;
    lines(6);
    `CHK(n_fetch - base, 0)
    end_test("split");
    // cursor rows with skip of 4 from line 2
    wr32(`CVSC_OFF_CURSOR_Y, 32'h0000_2002);
    wr32(`CVSC_OFF_CTRL, 32'h0000_0002);
    cvsc_pix_src_i.next_frame();
    lines(1);
    `CHK(cursor_line_active, 1'b0)
    lines(1);
    `CHK({cursor_line_active, cursor_pattern_row}, 6'h24)
    lines(27);
    `CHK({cursor_line_active, cursor_pattern_row}, 6'h3f)
    lines(1);
    `CHK(cursor_line_active, 1'b0)
    end_test("cursor");
    // cursor row as line compare, cursor display off
    wr32(`CVSC_OFF_CTRL, 32'h0000_0004);
    cvsc_pix_src_i.next_frame();
    base = n_hit;
    lines(4);
    `CHK(n_hit - base, 1)
    `CHK(cursor_line_active, 1'b0)
    end_test("compare");
    complete_run();
  end
endmodule // cvsc_regs_bench
`default_nettype wire
